// *** hdl/adcc_params.svh ***
`ifndef ADCC_PARAMS_SVH
`define ADCC_PARAMS_SVH

// Synchroniser depth for pins from outside the core clock domain
`define ADCC_SYNC_STAGES   3
// Pin positions inside the synchronised input vector
`define ADCC_PIN_CS        0
`define ADCC_PIN_RD        1
`define ADCC_PIN_CLK       2
`define ADCC_PIN_TEST      3
`define ADCC_PIN_COUNT     4
// Applied clock falling edges counted from the start of a conversion
`define ADCC_EDGE_CNT_W    5
`define ADCC_EDGE_CLEAR    5'h02
`define ADCC_EDGE_HOLD     5'h03
`define ADCC_EDGE_STEP0    5'h06
`define ADCC_EDGE_END      5'h14
// Reset values
`define ADCC_DATA_RST      8'h00
`define ADCC_BUSY_N_RST    1'b1

`endif

// *** hdl/adcc_pkg.sv ***
package adcc_pkg;

   typedef enum logic [2:0] {
      ADCC_ST_IDLE = 3'b001,
      ADCC_ST_CONV = 3'b010,
      ADCC_ST_DONE = 3'b100
   } adcc_state_t;

endpackage

// *** hdl/adcc_sar_if.sv ***
`timescale 1ns/1ns
interface adcc_sar_if #(
   parameter int DATA_W = 8,
   parameter int SMP_W  = 12
);
   logic              track;
   logic              clear;
   logic              step;
   logic [SMP_W-1:0]  level;
   logic [DATA_W-1:0] result;

   modport ctrl   (output track, output clear, output step, output level, input result);
   modport engine (input track, input clear, input step, input level, output result);
endinterface

// *** hdl/adcc_sar.sv ***
`timescale 1ns/1ns
`include "adcc_params.svh"
module adcc_sar #(
   parameter int DATA_W = 8,
   parameter int SMP_W  = 12
) (
   // Clock and reset
   input  wire logic   core_clk,
   input  wire logic   resetn,
   // Control from the sequencer
   adcc_sar_if.engine  sif
);
   import adcc_pkg::*;

   localparam int FRAC_W = SMP_W - DATA_W;
   localparam logic [SMP_W:0] HALF_LSB = (SMP_W+1)'(1) << (FRAC_W - 1);

   logic [SMP_W-1:0]  sample_reg;
   logic [SMP_W-1:0]  sample_next;
   logic [DATA_W-1:0] sar_reg;
   logic [DATA_W-1:0] sar_next;
   logic [DATA_W-1:0] bit_reg;
   logic [DATA_W-1:0] bit_next;
   logic [DATA_W-1:0] trial;
   logic              keep_bit;

   assign trial    = sar_reg | bit_reg;
   // Rounded comparison gives floor(code + 0.5) over the level fraction
   assign keep_bit = ({1'b0, sample_reg} + HALF_LSB) >= {1'b0, trial, {FRAC_W{1'b0}}};
   assign sif.result = sar_reg;

   always_comb begin
      sample_next = sample_reg;
      sar_next    = sar_reg;
      bit_next    = bit_reg;
      if (sif.track) begin
         sample_next = sif.level;
      end
      if (sif.clear) begin
         sar_next = '0;
         bit_next = {1'b1, {(DATA_W-1){1'b0}}};
      end else if (sif.step) begin
         if (keep_bit) begin
            sar_next = trial;
         end
         bit_next = bit_reg >> 1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sample_reg <= '0;
         sar_reg    <= '0;
         bit_reg    <= '0;
      end else begin
         sample_reg <= sample_next;
         sar_reg    <= sar_next;
         bit_reg    <= bit_next;
      end
   end

   property p_sar_clear;
      @(posedge core_clk) disable iff (!resetn)
      sif.clear |=> (sar_reg == '0) && bit_reg[DATA_W-1];
   endproperty
   a_sar_clear: assert property (p_sar_clear) else $error("SAR not cleared");

   property p_sar_decide;
      @(posedge core_clk) disable iff (!resetn)
      (sif.step && !sif.clear) |=> sar_reg == ($past(keep_bit) ? $past(trial) : $past(sar_reg));
   endproperty
   a_sar_decide: assert property (p_sar_decide) else $error("SAR bit decision wrong");

   property p_sar_track;
      @(posedge core_clk) disable iff (!resetn)
      sif.track |=> sample_reg == $past(sif.level);
   endproperty
   a_sar_track: assert property (p_sar_track) else $error("Sample not tracking");

   property p_sar_hold;
      @(posedge core_clk) disable iff (!resetn)
      !sif.track |=> $stable(sample_reg);
   endproperty
   a_sar_hold: assert property (p_sar_hold) else $error("Held sample moved");
endmodule

// *** hdl/adcc_top.sv ***
`timescale 1ns/1ns
`include "adcc_params.svh"
// Overview of operation
// - Chip select and read low start conversion
// - Busy goes low after conversion start
// - Hold input on third applied clock fall
// - Starting read returns previous conversion result
// - Busy low throughout conversion, high after
// - Read within one clock after busy: no start
// - Read during conversion returns old data
// - Code is floor(256*Vin/2Vref + 0.5)
// - Clock halved; conversion is 20 applied clocks
// - Internal clock stops when conversion completes
// - SAR cleared on first internal clock pulse
// - Sample stage tracks input between conversions
module adcc_top #(
   parameter int DATA_W = 8,
   parameter int SMP_W  = 12
) (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               resetn,
   // Host read port
   input  wire logic               cs_n_pin,
   input  wire logic               rd_n_pin,
   output logic                    busy_n,
   output logic [DATA_W-1:0]       data_out,
   output logic                    data_oe,
   // Converter clock and strap
   input  wire logic               conv_clk_pin,
   input  wire logic               factory_test_input,
   // Analog front end level and sample stage state
   input  wire logic [SMP_W-1:0]   ain_level,
   output logic                    track_mode
);
   import adcc_pkg::*;

   localparam int NP = `ADCC_PIN_COUNT;
   localparam int CW = `ADCC_EDGE_CNT_W;

   logic [NP-1:0]      pins;
   logic [NP-1:0]      s1_reg;
   logic [NP-1:0]      s2_reg;
   logic [NP-1:0]      s3_reg;
   logic [NP-1:0]      filt_reg;
   logic [NP-1:0]      filt_next;
   logic               sel;
   logic               sel_prev_reg;
   logic               clk_prev_reg;
   logic               sel_rise;
   logic               fall;
   adcc_state_t        state_reg;
   adcc_state_t        state_next;
   logic [CW-1:0]      cnt_reg;
   logic [CW-1:0]      cnt_next;
   logic               grace_reg;
   logic               grace_next;
   logic               busy_n_reg;
   logic               busy_n_next;
   logic [DATA_W-1:0]  data_out_reg;
   logic [DATA_W-1:0]  data_out_next;
   logic               data_oe_reg;
   logic               track_reg;
   logic               track_next;

   adcc_sar_if #(.DATA_W(DATA_W), .SMP_W(SMP_W)) sif ();

   adcc_sar #(.DATA_W(DATA_W), .SMP_W(SMP_W)) u_sar (
      .core_clk (core_clk),
      .resetn   (resetn),
      .sif      (sif)
   );

   assign pins[`ADCC_PIN_CS]   = cs_n_pin;
   assign pins[`ADCC_PIN_RD]   = rd_n_pin;
   assign pins[`ADCC_PIN_CLK]  = conv_clk_pin;
   assign pins[`ADCC_PIN_TEST] = factory_test_input;

   // Three-stage synchronisers; a change is taken once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_sync
         always_comb begin
            filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
         end
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               s1_reg[gi]   <= 1'b1;
               s2_reg[gi]   <= 1'b1;
               s3_reg[gi]   <= 1'b1;
               filt_reg[gi] <= 1'b1;
            end else begin
               s1_reg[gi]   <= pins[gi];
               s2_reg[gi]   <= s1_reg[gi];
               s3_reg[gi]   <= s2_reg[gi];
               filt_reg[gi] <= filt_next[gi];
            end
         end
      end
   endgenerate

   assign sel      = ~filt_reg[`ADCC_PIN_CS] & ~filt_reg[`ADCC_PIN_RD];
   assign sel_rise = sel & ~sel_prev_reg;
   assign fall     = clk_prev_reg & ~filt_reg[`ADCC_PIN_CLK];
   assign sif.level = ain_level;

   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      grace_next    = grace_reg;
      busy_n_next   = busy_n_reg;
      data_out_next = data_out_reg;
      track_next    = track_reg;
      sif.clear     = 1'b0;
      sif.step      = 1'b0;
      case (state_reg)
         ADCC_ST_IDLE: begin
            track_next = 1'b1;
            if (fall) begin
               grace_next = 1'b0;
            end
            // A select edge inside the grace window only reads the data
            if (sel_rise && !grace_reg && filt_reg[`ADCC_PIN_TEST]) begin
               state_next  = ADCC_ST_CONV;
               cnt_next    = '0;
               busy_n_next = 1'b0;
               grace_next  = 1'b0;
            end
         end
         ADCC_ST_CONV: begin
            // Further selects are not restarts; the old latch is read out
            if (fall) begin
               cnt_next = cnt_reg + CW'(1);
               if (cnt_next == `ADCC_EDGE_CLEAR) begin
                  sif.clear = 1'b1;
               end
               if (cnt_next == `ADCC_EDGE_HOLD) begin
                  track_next = 1'b0;
               end
               if (!cnt_next[0] && cnt_next >= `ADCC_EDGE_STEP0) begin
                  sif.step = 1'b1;
               end
               if (cnt_next == `ADCC_EDGE_END) begin
                  state_next = ADCC_ST_DONE;
               end
            end
         end
         ADCC_ST_DONE: begin
            data_out_next = sif.result;
            busy_n_next   = 1'b1;
            grace_next    = 1'b1;
            track_next    = 1'b1;
            state_next    = ADCC_ST_IDLE;
         end
         default: begin
            state_next = ADCC_ST_IDLE;
         end
      endcase
   end

   assign sif.track = track_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg    <= ADCC_ST_IDLE;
         cnt_reg      <= '0;
         grace_reg    <= 1'b0;
         busy_n_reg   <= `ADCC_BUSY_N_RST;
         data_out_reg <= `ADCC_DATA_RST;
         data_oe_reg  <= 1'b0;
         track_reg    <= 1'b1;
         sel_prev_reg <= 1'b0;
         clk_prev_reg <= 1'b1;
      end else begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         grace_reg    <= grace_next;
         busy_n_reg   <= busy_n_next;
         data_out_reg <= data_out_next;
         data_oe_reg  <= sel;
         track_reg    <= track_next;
         sel_prev_reg <= sel;
         clk_prev_reg <= filt_reg[`ADCC_PIN_CLK];
      end
   end

   assign busy_n     = busy_n_reg;
   assign data_out   = data_out_reg;
   assign data_oe    = data_oe_reg;
   assign track_mode = track_reg;

   sequence s_start;
      (state_reg == ADCC_ST_IDLE) && sel_rise && !grace_reg && filt_reg[`ADCC_PIN_TEST];
   endsequence

   sequence s_finish;
      (state_reg == ADCC_ST_DONE);
   endsequence

   property p_busy_start;
      @(posedge core_clk) disable iff (!resetn)
      s_start |=> !busy_n_reg && (state_reg == ADCC_ST_CONV) && (cnt_reg == '0);
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("Busy not low after start");

   property p_busy_conv;
      @(posedge core_clk) disable iff (!resetn)
      (state_reg == ADCC_ST_CONV) |-> !busy_n_reg;
   endproperty
   a_busy_conv: assert property (p_busy_conv) else $error("Busy high during conversion");

   property p_hold_third;
      @(posedge core_clk) disable iff (!resetn)
      $fell(track_reg) |-> $past(fall) && (cnt_reg == `ADCC_EDGE_HOLD);
   endproperty
   a_hold_third: assert property (p_hold_third) else $error("Hold not on third fall");

   property p_latch_new;
      @(posedge core_clk) disable iff (!resetn)
      s_finish |=> busy_n_reg && (data_out_reg == $past(sif.result)) && track_reg;
   endproperty
   a_latch_new: assert property (p_latch_new) else $error("Result not latched at busy rise");

   property p_end_count;
      @(posedge core_clk) disable iff (!resetn)
      $rose(state_reg == ADCC_ST_DONE) |-> cnt_reg == `ADCC_EDGE_END;
   endproperty
   a_end_count: assert property (p_end_count) else $error("Conversion length wrong");

   property p_oe;
      @(posedge core_clk) disable iff (!resetn)
      sel |=> data_oe_reg ##0 (!sel_prev_reg || $stable(data_out_reg) || $rose(busy_n_reg));
   endproperty
   a_oe: assert property (p_oe) else $error("Data not driven while selected");

   property p_oe_off;
      @(posedge core_clk) disable iff (!resetn)
      !sel |=> !data_oe_reg;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("Data driven while deselected");

   property p_stale;
      @(posedge core_clk) disable iff (!resetn)
      s_start |=> data_oe_reg && $stable(data_out_reg);
   endproperty
   a_stale: assert property (p_stale) else $error("Starting read lost old data");

   property p_grace;
      @(posedge core_clk) disable iff (!resetn)
      (state_reg == ADCC_ST_IDLE) && grace_reg && sel_rise |=> busy_n_reg;
   endproperty
   a_grace: assert property (p_grace) else $error("Read in grace window restarted");

   property p_stop;
      @(posedge core_clk) disable iff (!resetn)
      (state_reg != ADCC_ST_CONV) |-> !sif.step && !sif.clear;
   endproperty
   a_stop: assert property (p_stop) else $error("Internal clock ran while idle");

   property p_strap;
      @(posedge core_clk) disable iff (!resetn)
      (state_reg == ADCC_ST_IDLE) && sel_rise && !filt_reg[`ADCC_PIN_TEST]
         |=> busy_n_reg && (state_reg == ADCC_ST_IDLE);
   endproperty
   a_strap: assert property (p_strap) else $error("Start taken with strap low");
endmodule

// *** test/adcc_host.sv ***
`timescale 1ns/1ns
module adcc_host (
   // Clocks
   input  wire logic       core_clk,
   input  wire logic       conv_clk_pin,
   // Read port
   output logic            cs_n_pin,
   output logic            rd_n_pin,
   input  wire logic       busy_n,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe
);
   initial begin
      cs_n_pin = 1'b1;
      rd_n_pin = 1'b1;
   end

   // Aligned starts fall 28 ns after a converter clock fall, so the hold edge is fixed
   task automatic start_read(input bit align);
      if (align) begin
         @(negedge conv_clk_pin);
         repeat (6) @(negedge core_clk);
      end
      @(negedge core_clk);
      cs_n_pin <= 1'b0;
      rd_n_pin <= 1'b0;
   endtask

   task automatic end_read();
      @(negedge core_clk);
      cs_n_pin <= 1'b1;
      rd_n_pin <= 1'b1;
   endtask

   // Busy polled as a completion flag; a stretched read stays selected meanwhile
   task automatic wait_busy(input logic lvl, output bit ok);
      ok = 1'b0;
      for (int i = 0; i < 3000 && !ok; i++) begin
         @(negedge core_clk);
         ok = (busy_n === lvl);
      end
   endtask

   // A released bus reads as the inverse of the latch, never as the last value
   task automatic sample(output logic [7:0] d);
      @(negedge core_clk);
      d = data_oe ? data_out : ~data_out;
   endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ns
module testbench;
   localparam logic [11:0] LVLS [6] = '{12'h3E8, 12'hFFF, 12'h007, 12'h008, 12'hFF7, 12'h000};
   logic        core_clk;
   logic        resetn;
   logic        conv_clk_pin = 1'b1;
   logic        cs_n_pin;
   logic        rd_n_pin;
   logic        busy_n;
   logic [7:0]  data_out;
   logic        data_oe;
   logic [11:0] ain_level;
   logic        track_mode;
   logic        factory_test_input;
   logic [7:0]  prev_code;
   int          fails = 0;
   int          check_count = 0;
   int          fall_cnt = 0;
   int          hold_at = 0;
   int          div_cnt = 0;

   adcc_top dut_u (
      .core_clk(core_clk), .resetn(resetn), .cs_n_pin(cs_n_pin), .rd_n_pin(rd_n_pin),
      .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe),
      .conv_clk_pin(conv_clk_pin), .factory_test_input(factory_test_input),
      .ain_level(ain_level), .track_mode(track_mode));

   adcc_host host_u (
      .core_clk(core_clk), .conv_clk_pin(conv_clk_pin), .cs_n_pin(cs_n_pin),
      .rd_n_pin(rd_n_pin), .busy_n(busy_n), .data_out(data_out), .data_oe(data_oe));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   // Converter clock of 80 ns, running freely between conversions
   always @(negedge core_clk) begin
      if (div_cnt == 9) begin
         div_cnt <= 0;
         conv_clk_pin <= ~conv_clk_pin;
      end else begin
         div_cnt <= div_cnt + 1;
      end
   end

   always @(negedge conv_clk_pin) fall_cnt++;
   always @(negedge track_mode) hold_at = fall_cnt;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   function automatic logic [7:0] exp_code(input int a);
      int c;
      c = (a + 8) / 16;
      return (c > 255) ? 8'hFF : c[7:0];
   endfunction

   // Slow memory read: one stretched read starts and fetches
   task automatic t_slow(input logic [11:0] lvl);
      bit         ok;
      int         f0;
      logic [7:0] d;
      ain_level = lvl;
      host_u.start_read(1'b1);
      host_u.wait_busy(1'b0, ok);
      check(ok, 1, "busy low");
      f0 = fall_cnt;
      host_u.sample(d);
      check(d, prev_code, "stale data");
      host_u.wait_busy(1'b1, ok);
      check(ok, 1, "busy high");
      check(fall_cnt - f0, 20, "conversion length");
      check(hold_at - f0, 3, "hold edge");
      check(track_mode, 1, "tracking");
      host_u.sample(d);
      prev_code = exp_code(lvl);
      check(d, prev_code, "new code");
      host_u.end_read();
      repeat (8) @(negedge core_clk);
      check(data_oe, 0, "bus released");
   endtask

   // Two-read scheme, grace read, normal restart and read during conversion
   task automatic t_rom(input logic [11:0] lvl);
      bit         ok;
      int         f0;
      logic [7:0] d;
      ain_level = lvl;
      host_u.start_read(1'b1);
      host_u.wait_busy(1'b0, ok);
      host_u.sample(d);
      check(d, prev_code, "rom stale data");
      host_u.end_read();
      host_u.wait_busy(1'b1, ok);
      prev_code = exp_code(lvl);
      host_u.start_read(1'b0);
      repeat (40) @(negedge core_clk);
      check(busy_n, 1, "grace read");
      host_u.sample(d);
      check(d, prev_code, "rom new code");
      host_u.end_read();
      repeat (8) @(negedge core_clk);
      host_u.start_read(1'b1);
      host_u.wait_busy(1'b0, ok);
      check(ok, 1, "second read starts");
      f0 = fall_cnt;
      host_u.end_read();
      repeat (60) @(negedge core_clk);
      host_u.start_read(1'b0);
      repeat (8) @(negedge core_clk);
      host_u.sample(d);
      check(d, prev_code, "read during conversion");
      host_u.end_read();
      host_u.wait_busy(1'b1, ok);
      check(fall_cnt - f0, 20, "no restart");
   endtask

   // Strap pulled low: a select only reads the latch and starts nothing
   task automatic t_strap();
      logic [7:0] d;
      factory_test_input = 1'b0;
      repeat (8) @(negedge core_clk);
      host_u.start_read(1'b1);
      repeat (40) @(negedge core_clk);
      check(busy_n, 1, "strap low no start");
      check(track_mode, 1, "strap low tracking");
      host_u.sample(d);
      check(d, prev_code, "strap low data");
      host_u.end_read();
      repeat (8) @(negedge core_clk);
      factory_test_input = 1'b1;
      repeat (8) @(negedge core_clk);
   endtask

   task automatic complete_run();
      $display("Checks %0d, failures %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      factory_test_input = 1'b1;
      ain_level = 12'h000;
      prev_code = 8'h00;
      repeat (10) @(negedge core_clk);
      check(busy_n, 1, "reset busy");
      check(data_oe, 0, "reset bus");
      check(track_mode, 1, "reset track");
      resetn = 1'b1;
      repeat (4) @(negedge core_clk);
      foreach (LVLS[i]) t_slow(LVLS[i]);
      t_rom(12'h5A3);
      t_strap();
      t_slow(12'h800);
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      complete_run();
   end
endmodule
